// ===== inc/pas_defs.svh
`ifndef PAS_DEFS_SVH
`define PAS_DEFS_SVH

// Register offsets
`define PAS_REG_SUMMARY 8'h0b
`define PAS_REG_MASK 8'h0c
`define PAS_REG_CONN_CHG 8'h0d
`define PAS_REG_CONN_STATE 8'h0e
`define PAS_REG_MON_CHG 8'h0f
`define PAS_REG_MON_STATE 8'h10
`define PAS_REG_SUP_THR 8'h20
`define PAS_REG_BUS_RANGE 8'h22
`define PAS_REG_BUS_THR 8'h2e

// Alert field: bits 6:4 of summary and mask
`define PAS_ALERT_CONN 2
`define PAS_ALERT_MON 1
`define PAS_ALERT_HW 0

// Reset values
`define PAS_SUMMARY_RST 3'h2
`define PAS_MASK_RST 3'h7
`define PAS_MASK_RSVD_HI 1'h1
`define PAS_MASK_RSVD_LO 4'hf
`define PAS_MON_STATE_RST 4'h4
`define PAS_CTRL_RST 8'h00
// Pin sync reset: scl, sda idle high; bus safe-zero high
`define PAS_PIN_RST 13'h1804

// Upper six bits of the 7-bit slave address, low bit from strap
`define PAS_DEV_ADDR_HI 6'h14
// Sync pipeline depth before status is trusted
`define PAS_PRIME_CNT 2'h3

`endif

// ===== inc/pas_pkg.sv
package pas_pkg;

  typedef enum logic [4:0] {
    st_idle = 5'h01,
    st_addr = 5'h02,
    st_reg = 5'h04,
    st_wr = 5'h08,
    st_rd = 5'h10
  } pas_i2c_state_t;

endpackage : pas_pkg

// ===== hdl/pas_regs.sv
`timescale 1ns/10ps
`include "pas_defs.svh"
// Summary of operation
// - Connection change, monitor change and hardware fault events set summary bits 6, 5, 4 respectively.
// - Summary and transition registers clear the bits returned by a read.
// - A set mask bit blocks its summary bit and its interrupt.
// - Alert pin driven low while summary AND NOT mask is nonzero.
// - Reset values apply after reset; mask and mode bits load from NVM.
// - Attach change sets connection change bit 0; bits 7:1 read zero.
// - Connection bits 7:5 report the attached party code.
// - Connection bit 4 shows normal (0) or standby (1) power mode.
// - Standby disabled after reset unless NVM enables it.
// - Monitor status changes set monitor change bits 3:0; 7:4 read zero.
// - Monitor bits 3, 2, 1 reflect bus valid, safe-zero, presence.
// - Safe-zero status resets to one.
// - Connector supply bit follows the detector once out of reset.
// - Bus valid window follows a rewritable range control register.
// - Bus lockout and supply lockout each from their own control register.
// - After reset summary reads monitor bit set, others zero.
// - Registers reached over an I2C slave, one address byte then data.
module pas_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_sel_pin,
  input wire logic [2:0] nvm_alert_mask,
  input wire logic nvm_standby_en,
  input wire logic [2:0] attached_party_code,
  input wire logic source_role_flag,
  input wire logic connector_supply_on_flag,
  input wire logic attached_flag,
  input wire logic bus_in_range_flag,
  input wire logic bus_safe_zero_flag,
  input wire logic bus_present_flag,
  input wire logic connector_supply_present_flag,
  input wire logic hardware_fault_alert_event,
  output logic alert_out,
  output logic alert_oe,
  output logic [7:0] bus_range_control,
  output logic [7:0] bus_threshold_control,
  output logic [7:0] connector_supply_threshold_control
);

  ////////////////////////////////////////////////////////////////////////////
  logic [12:0] pin_raw;
  logic [12:0] pin_meta;
  logic [12:0] pin_sync;
  logic scl_s, sda_s;
  logic scl_prev_reg, sda_prev_reg;
  logic scl_rise, scl_fall;
  logic start_cond, stop_cond;
  logic [1:0] prime_cnt_reg;
  logic primed;
  logic [5:0] conn_live;
  logic [3:0] mon_live;
  logic [5:0] conn_state_reg;
  logic [3:0] mon_state_reg;
  logic power_mode_reg;
  logic conn_chg_reg;
  logic [3:0] mon_chg_reg;
  logic [2:0] summary_reg;
  logic [2:0] mask_reg;
  logic attach_evt;
  logic [3:0] mon_evt;
  logic [2:0] alert_set;
  pas_pkg::pas_i2c_state_t state_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic ack_slot_reg, rw_reg, mack_reg;
  logic [7:0] reg_ptr_reg;
  logic byte_done, addr_hit, rd_load, wr_stb;
  logic [7:0] rd_data;

  // Comparator outputs are asynchronous to clk, so they share the pin syncs
  assign pin_raw = {scl_in, sda_in, addr_sel_pin, attached_party_code, source_role_flag,
                    connector_supply_on_flag, attached_flag, bus_in_range_flag,
                    bus_safe_zero_flag, bus_present_flag, connector_supply_present_flag};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= `PAS_PIN_RST;
      pin_sync <= `PAS_PIN_RST;
    end else if (ce) begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  assign scl_s = pin_sync[12];
  assign sda_s = pin_sync[11];
  assign conn_live = pin_sync[9:4];
  assign mon_live = pin_sync[3:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else if (ce) begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_prev_reg;
  assign scl_fall = !scl_s && scl_prev_reg;
  assign start_cond = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
  assign stop_cond = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Startup: syncs hold reset constants until filled, so no change is
  // flagged and straps are caught only once they are real
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prime_cnt_reg <= 2'h0;
    end else if (ce && !primed) begin
      prime_cnt_reg <= prime_cnt_reg + 2'h1;
    end
  end

  assign primed = (prime_cnt_reg == `PAS_PRIME_CNT);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_mode_reg <= 1'b0;
      mask_reg <= `PAS_MASK_RST;
    end else if (ce) begin
      if (!primed) begin
        power_mode_reg <= nvm_standby_en;
        mask_reg <= nvm_alert_mask;
      end else if (wr_stb && reg_ptr_reg == `PAS_REG_MASK) begin
        mask_reg <= shift_reg[6:4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Live status and change detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conn_state_reg <= 6'h00;
      mon_state_reg <= `PAS_MON_STATE_RST;
    end else if (ce) begin
      conn_state_reg <= conn_live;
      mon_state_reg <= mon_live;
    end
  end

  assign attach_evt = primed && (conn_live[0] != conn_state_reg[0]);
  assign mon_evt = primed ? (mon_live ^ mon_state_reg) : 4'h0;
  // Masked alerts never set, so unmasking later raises nothing stale
  assign alert_set = {attach_evt, |mon_evt, hardware_fault_alert_event} & ~mask_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conn_chg_reg <= 1'b0;
      mon_chg_reg <= 4'h0;
    end else if (ce) begin
      conn_chg_reg <= ((rd_load && reg_ptr_reg == `PAS_REG_CONN_CHG) ? 1'b0 : conn_chg_reg)
                      | attach_evt;
      mon_chg_reg <= ((rd_load && reg_ptr_reg == `PAS_REG_MON_CHG) ? 4'h0 : mon_chg_reg)
                     | mon_evt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      summary_reg <= `PAS_SUMMARY_RST;
    end else if (ce) begin
      summary_reg <= ((rd_load && reg_ptr_reg == `PAS_REG_SUMMARY) ? 3'h0 : summary_reg)
                     | alert_set;
    end
  end

  // Open-drain alert: only ever pulls low
  assign alert_out = 1'b0;
  assign alert_oe = |(summary_reg & ~mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Monitor control registers feed the analog comparators outside
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_range_control <= `PAS_CTRL_RST;
      bus_threshold_control <= `PAS_CTRL_RST;
      connector_supply_threshold_control <= `PAS_CTRL_RST;
    end else if (ce && wr_stb) begin
      case (reg_ptr_reg)
        `PAS_REG_BUS_RANGE: bus_range_control <= shift_reg;
        `PAS_REG_BUS_THR: bus_threshold_control <= shift_reg;
        `PAS_REG_SUP_THR: connector_supply_threshold_control <= shift_reg;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (reg_ptr_reg)
      `PAS_REG_SUMMARY: rd_data = {1'b0, summary_reg, 4'h0};
      `PAS_REG_MASK: rd_data = {`PAS_MASK_RSVD_HI, mask_reg, `PAS_MASK_RSVD_LO};
      `PAS_REG_CONN_CHG: rd_data = {7'h00, conn_chg_reg};
      `PAS_REG_CONN_STATE: rd_data = {conn_state_reg[5:3], power_mode_reg,
                                      conn_state_reg[2], 1'b0, conn_state_reg[1:0]};
      `PAS_REG_MON_CHG: rd_data = {4'h0, mon_chg_reg};
      `PAS_REG_MON_STATE: rd_data = {4'h0, mon_state_reg};
      `PAS_REG_BUS_RANGE: rd_data = bus_range_control;
      `PAS_REG_BUS_THR: rd_data = bus_threshold_control;
      `PAS_REG_SUP_THR: rd_data = connector_supply_threshold_control;
      default: rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // I2C slave; pointer auto-increments after each data byte
  assign byte_done = !ack_slot_reg && bit_cnt_reg == 4'h8;
  assign addr_hit = shift_reg[7:1] == {`PAS_DEV_ADDR_HI, pin_sync[10]};
  assign rd_load = ce && scl_fall && ack_slot_reg &&
                   ((state_reg == pas_pkg::st_addr && rw_reg) ||
                    (state_reg == pas_pkg::st_rd && mack_reg));
  assign wr_stb = ce && scl_fall && byte_done && state_reg == pas_pkg::st_wr;
  assign sda_out = 1'b0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= pas_pkg::st_idle;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      ack_slot_reg <= 1'b0;
      rw_reg <= 1'b0;
      mack_reg <= 1'b0;
      sda_oe <= 1'b0;
      reg_ptr_reg <= 8'h00;
    end else if (ce) begin
      if (start_cond) begin
        state_reg <= pas_pkg::st_addr;
        bit_cnt_reg <= 4'h0;
        ack_slot_reg <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_cond) begin
        state_reg <= pas_pkg::st_idle;
        ack_slot_reg <= 1'b0;
        sda_oe <= 1'b0;
      end else if (scl_rise && state_reg != pas_pkg::st_idle) begin
        if (ack_slot_reg) begin
          mack_reg <= !sda_s;
        end else begin
          shift_reg <= {shift_reg[6:0], sda_s};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
      end else if (scl_fall && state_reg != pas_pkg::st_idle) begin
        if (byte_done) begin
          ack_slot_reg <= 1'b1;
          bit_cnt_reg <= 4'h0;
          case (state_reg)
            pas_pkg::st_addr: begin
              if (addr_hit) begin
                sda_oe <= 1'b1;
                rw_reg <= shift_reg[0];
              end else begin
                state_reg <= pas_pkg::st_idle;
              end
            end
            pas_pkg::st_reg: begin
              reg_ptr_reg <= shift_reg;
              sda_oe <= 1'b1;
            end
            pas_pkg::st_wr: begin
              reg_ptr_reg <= reg_ptr_reg + 8'h01;
              sda_oe <= 1'b1;
            end
            default: sda_oe <= 1'b0;
          endcase
        end else if (ack_slot_reg) begin
          ack_slot_reg <= 1'b0;
          if (rd_load) begin
            state_reg <= pas_pkg::st_rd;
            shift_reg <= rd_data;
            sda_oe <= !rd_data[7];
            reg_ptr_reg <= reg_ptr_reg + 8'h01;
          end else begin
            sda_oe <= 1'b0;
            case (state_reg)
              pas_pkg::st_addr: state_reg <= pas_pkg::st_reg;
              pas_pkg::st_reg: state_reg <= pas_pkg::st_wr;
              pas_pkg::st_rd: state_reg <= pas_pkg::st_idle;
              default: ;
            endcase
          end
        end else if (state_reg == pas_pkg::st_rd) begin
          sda_oe <= !shift_reg[7];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_conn_alert_set: assert property (ce && attach_evt && !mask_reg[2] |=> summary_reg[2])
    else $error("connection alert not set");
  a_mon_alert_set: assert property (ce && (|mon_evt) && !mask_reg[1] |=> summary_reg[1])
    else $error("monitor alert not set");
  a_masked_hold: assert property (ce && mask_reg[2] && !summary_reg[2] |=> !summary_reg[2])
    else $error("masked alert was set");
  a_alert_pin_low: assert property (ce && (|mon_evt) && !mask_reg[1] |=> alert_oe)
    else $error("alert pin not driven");
  a_chg_read_clear: assert property (rd_load && reg_ptr_reg == `PAS_REG_MON_CHG && !(|mon_evt)
                                     |=> mon_chg_reg == 4'h0)
    else $error("monitor change flags not cleared by read");
  a_set_wins_clear: assert property (rd_load && attach_evt |=> conn_chg_reg)
    else $error("attach change lost on clearing read");
  a_attach_flagged: assert property (ce && primed && conn_live[0] != conn_state_reg[0]
                                     |=> conn_chg_reg && conn_state_reg[0] == $past(conn_live[0]))
    else $error("attach change not flagged");
  a_party_code: assert property (ce |=> conn_state_reg[5:3] == $past(conn_live[5:3]))
    else $error("party code not tracked");
  a_mode_stable: assert property (ce && primed |=> $stable(power_mode_reg))
    else $error("power mode changed after startup");
  a_mask_rsvd_ones: assert property (rd_load && reg_ptr_reg == `PAS_REG_MASK
                                     |=> shift_reg[7] && shift_reg[3:0] == 4'hf)
    else $error("mask reserved bits not one");
  a_read_on_ack: assert property (rd_load |=> state_reg == pas_pkg::st_rd && !ack_slot_reg)
    else $error("read byte not loaded");

  c_alert_raised: cover property (!alert_oe ##1 alert_oe);
  c_summary_read: cover property (rd_load && reg_ptr_reg == `PAS_REG_SUMMARY);
  c_mask_write: cover property (wr_stb && reg_ptr_reg == `PAS_REG_MASK);
  c_attach_change: cover property (attach_evt);

endmodule : pas_regs

// ===== tb/pas_host.sv
`timescale 1ns/10ps
module pas_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // Also serves as repeated start, entered with scl low
  task automatic start();
    sda_low <= 1'h0;
    tick(6);
    scl <= 1'h1;
    tick(12);
    sda_low <= 1'h1;
    tick(12);
    scl <= 1'h0;
    tick(6);
  endtask : start
  task automatic stop();
    sda_low <= 1'h1;
    tick(6);
    scl <= 1'h1;
    tick(12);
    sda_low <= 1'h0;
    tick(12);
  endtask : stop
  // Eight bits MSB first, then the acknowledge slot; sampled mid-high
  task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] q,
                      output logic r9);
    logic [8:0] o;
    logic [8:0] i;
    o = {d, b9};
    for (int k = 8; k >= 0; k--) begin
      sda_low <= !o[k];
      tick(6);
      scl <= 1'h1;
      tick(6);
      i[k] = sda;
      tick(6);
      scl <= 1'h0;
      tick(6);
    end
    q = i[8:1];
    r9 = i[0];
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic [2:0] r;
    start();
    xfer(8'h50, 1'h1, q, r[0]);
    xfer(a, 1'h1, q, r[1]);
    xfer(d, 1'h1, q, r[2]);
    stop();
    ok = !(|r);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic [3:0] r;
    start();
    xfer(8'h50, 1'h1, q, r[0]);
    xfer(a, 1'h1, q, r[1]);
    start();
    xfer(8'h51, 1'h1, q, r[2]);
    // Master NACK, so no second byte is loaded and cleared
    xfer(8'hff, 1'h1, d, r[3]);
    stop();
    ok = !(|r[2:0]);
  endtask : rd
  task automatic probe(input logic [7:0] b, output logic nak);
    logic [7:0] q;
    start();
    xfer(b, 1'h1, q, nak);
    stop();
  endtask : probe
endmodule : pas_host

// ===== tb/port_alert_status_regs_bench.sv
`timescale 1ns/10ps
module port_alert_status_regs_bench;
  logic clk, rst_n, ce, sda_oe, sda_out, alert_out, alert_oe, scl, sda_low;
  logic nvm_sb, hw_ev, role, sup_on, att, in_rng, safe0, pres, sup_pres, nak;
  logic [2:0] nvm_mask, party;
  logic [7:0] rng_ctl, thr_ctl, sup_ctl;
  // Pulled-up open-drain wire
  wire logic sda = (sda_low || sda_oe) ? 1'h0 : 1'h1;
  int errors = 0;
  int total_checks = 0;
  pas_regs dut (.clk(clk), .rst_n(rst_n), .ce(ce), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel_pin(1'h0), .nvm_alert_mask(nvm_mask),
    .nvm_standby_en(nvm_sb), .attached_party_code(party), .source_role_flag(role),
    .connector_supply_on_flag(sup_on), .attached_flag(att), .bus_in_range_flag(in_rng),
    .bus_safe_zero_flag(safe0), .bus_present_flag(pres),
    .connector_supply_present_flag(sup_pres), .hardware_fault_alert_event(hw_ev),
    .alert_out(alert_out), .alert_oe(alert_oe), .bus_range_control(rng_ctl),
    .bus_threshold_control(thr_ctl), .connector_supply_threshold_control(sup_ctl));
  pas_host host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.rd(a, d, ok);
    chk({7'h0, ok}, 8'h01);
    chk(d, exp);
  endtask : rc
  task automatic wc(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.wr(a, d, ok);
    chk({7'h0, ok}, 8'h01);
  endtask : wc
  task automatic do_reset(input logic [2:0] m, input logic sb);
    @(posedge clk);
    rst_n <= 1'h0;
    nvm_mask <= m;
    nvm_sb <= sb;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    repeat (6) @(posedge clk);
  endtask : do_reset
  // Covers the two-flop sync plus the flag update edge
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask : settle
  task automatic hw_pulse();
    @(posedge clk);
    hw_ev <= 1'h1;
    @(posedge clk);
    hw_ev <= 1'h0;
    settle();
  endtask : hw_pulse
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    do_reset(3'h5, 1'h1);
    chk({6'h0, sda_out, alert_out}, 8'h00);
    chk({7'h0, alert_oe}, 8'h01);
    rc(8'h0c, 8'hdf);
    rc(8'h0e, 8'h10);
    rc(8'h0b, 8'h20);
    chk({7'h0, alert_oe}, 8'h00);
    do_reset(3'h7, 1'h0);
    chk({7'h0, alert_oe}, 8'h00);
    rc(8'h0c, 8'hff);
    rc(8'h0e, 8'h00);
    rc(8'h10, 8'h04);
    rc(8'h0d, 8'h00);
    rc(8'h0f, 8'h00);
    rc(8'h0b, 8'h20);
    rc(8'h0b, 8'h00);
  endtask : t_reset
  task automatic t_access();
    wc(8'h0c, 8'h00);
    rc(8'h0c, 8'h8f);
    wc(8'h0e, 8'hff);
    rc(8'h0e, 8'h00);
    rc(8'h30, 8'h00);
    host.probe(8'ha0, nak);
    chk({7'h0, nak}, 8'h01);
  endtask : t_access
  task automatic t_monitor();
    in_rng <= 1'h1;
    settle();
    chk({7'h0, alert_oe}, 8'h01);
    rc(8'h0f, 8'h08);
    rc(8'h10, 8'h0c);
    rc(8'h0b, 8'h20);
    chk({7'h0, alert_oe}, 8'h00);
    safe0 <= 1'h0;
    pres <= 1'h1;
    sup_pres <= 1'h1;
    settle();
    rc(8'h0f, 8'h07);
    rc(8'h10, 8'h0b);
    rc(8'h0b, 8'h20);
  endtask : t_monitor
  task automatic t_conn();
    logic [2:0] codes [3];
    codes = '{3'h3, 3'h4, 3'h0};
    att <= 1'h1;
    party <= 3'h1;
    role <= 1'h1;
    sup_on <= 1'h1;
    settle();
    rc(8'h0d, 8'h01);
    rc(8'h0e, 8'h2b);
    rc(8'h0b, 8'h40);
    // Party code alone is not a tracked transition
    foreach (codes[k]) begin
      party <= codes[k];
      settle();
      rc(8'h0e, {codes[k], 5'h0b});
    end
    rc(8'h0d, 8'h00);
    rc(8'h0b, 8'h00);
  endtask : t_conn
  task automatic t_freeze();
    ce <= 1'h0;
    in_rng <= 1'h0;
    settle();
    chk({7'h0, alert_oe}, 8'h00);
    ce <= 1'h1;
    settle();
    chk({7'h0, alert_oe}, 8'h01);
    rc(8'h0f, 8'h08);
    rc(8'h0b, 8'h20);
  endtask : t_freeze
  task automatic t_race();
    logic [7:0] d;
    logic ok;
    // Attach edge meets the read load: 504 cycles to the read address byte,
    // 210 more to its ninth SCL fall, same sync depth on both paths
    fork
      host.rd(8'h0d, d, ok);
      begin
        repeat (714) @(posedge clk);
        att <= !att;
      end
    join
    chk({7'h0, ok}, 8'h01);
    chk(d, 8'h00);
    rc(8'h0d, 8'h01);
    rc(8'h0b, 8'h40);
  endtask : t_race
  task automatic t_mask();
    wc(8'h0c, 8'h70);
    rc(8'h0c, 8'hff);
    hw_pulse();
    chk({7'h0, alert_oe}, 8'h00);
    wc(8'h0c, 8'h60);
    chk({7'h0, alert_oe}, 8'h00);
    rc(8'h0b, 8'h00);
    hw_pulse();
    chk({7'h0, alert_oe}, 8'h01);
    rc(8'h0b, 8'h10);
  endtask : t_mask
  task automatic t_ctrl();
    wc(8'h20, 8'h5a);
    wc(8'h22, 8'ha5);
    wc(8'h2e, 8'h3c);
    chk(sup_ctl, 8'h5a);
    chk(rng_ctl, 8'ha5);
    chk(thr_ctl, 8'h3c);
    rc(8'h22, 8'ha5);
  endtask : t_ctrl
  ////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    // Roughly 40k cycles expected; the 70k-cycle limit sits well above that
    #700000;
    errors++;
    test_done();
  end
  initial begin
    rst_n = 1'h0;
    ce = 1'h1;
    nvm_mask = 3'h7;
    nvm_sb = 1'h0;
    hw_ev = 1'h0;
    party = 3'h0;
    role = 1'h0;
    sup_on = 1'h0;
    att = 1'h0;
    in_rng = 1'h0;
    safe0 = 1'h1;
    pres = 1'h0;
    sup_pres = 1'h0;
    t_reset();
    t_access();
    t_monitor();
    t_conn();
    t_freeze();
    t_race();
    t_mask();
    t_ctrl();
    test_done();
  end
endmodule : port_alert_status_regs_bench
